/* sit_defs.svh */
// Purpose: Constants of the sensor two-wire target read port.
// Assumes: Included by bare name; definitions only.
// Notes: Timing figures are in nanoseconds.
`ifndef SIT_DEFS_SVH
`define SIT_DEFS_SVH

// ----------------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------------
// Seven-bit target address answered by the port.
`define SIT_TARGET_ADDR 7'h6D
// Direction bit value that selects a read transfer.
`define SIT_DIR_READ 1'b1
// Bit index of the last data bit within a byte.
`define SIT_LAST_BIT 3'h7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
// Register pointer after reset.
`define SIT_PTR_RESET 8'h00

`endif

/* sit_host.sv */
// Purpose: Behavioural bus controller that reads one byte over the link.
// Assumes: Both lines have pull-ups; the bench resolves the wire levels.
// Notes: Timed by delays, so the link clock is unrelated to clk_i.
`timescale 1ns/10ps
`default_nettype none
module sit_host
(
    input wire logic sda_i,
    output var logic scl_low_o,
    output var logic sda_low_o
);
    // ------------------------------------------------------------------
    // Line drivers
    // ------------------------------------------------------------------
    // Both lines start released, so the pull-ups hold the idle bus high.
    initial
    begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end

    // One clock pulse of 160 ns. Data moves only while the clock is low.
    // The bit is sampled late in the high phase, so slow answers still land.
    task automatic pulse(input logic val_i, output logic smp_o);
        scl_low_o = 1'b1;
        #20 sda_low_o = ~val_i;
        #60 scl_low_o = 1'b0;
        #70 smp_o = sda_i;
        #10;
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        scl_low_o = 1'b1;
        #20 sda_low_o = 1'b0;
        #60 scl_low_o = 1'b0;
        #80 sda_low_o = 1'b1;
        #80;
    endtask

    // Stop: data rises while the clock is high; the clock then stands still.
    task automatic stop();
        scl_low_o = 1'b1;
        #20 sda_low_o = 1'b1;
        #60 scl_low_o = 1'b0;
        #80 sda_low_o = 1'b0;
        #80;
    endtask

    // Eight bits, most significant first, then the released answer pulse.
    task automatic send(input logic [7:0] b, output logic nak);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            pulse(b[i], s);
        end
        pulse(1'b1, nak);
    endtask

    // Eight bits from the device, answered with not-acknowledge.
    task automatic recv(output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            pulse(1'b1, b[i]);
        end
        pulse(1'b1, s);
    endtask
endmodule
`default_nettype wire

/* sit_pkg.sv */
// Purpose: Types of the sensor two-wire target read port.
// Assumes: Nothing beyond the constants header.
// Notes: Holds the protocol state enumeration only.
`default_nettype none
package sit_pkg;
    // Protocol states of the target engine.
    typedef enum logic [2:0]
    {
        SIT_IDLE,
        SIT_ADDR,
        SIT_ADDR_ACK,
        SIT_PTR,
        SIT_PTR_ACK,
        SIT_SEND,
        SIT_SEND_ACK
    } sit_state_type;
endpackage
`default_nettype wire

/* sit_target.sv */
// Purpose: Two-wire serial target that returns one byte from a register.
// Assumes: Link clock far slower than clk_i; both pins open drain.
// Notes: Register contents come from the user side as a read port.
`timescale 1ns/10ps
`default_nettype none
`include "sit_defs.svh"
module sit_target
    import sit_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [7:0] reg_addr_o,
    input wire logic [7:0] reg_data_i,
    output logic busy_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] scl_sync_q; // Two-stage capture of the clock pin.
    logic [1:0] sda_sync_q; // Two-stage capture of the data pin.
    logic scl_prev_q; // Previous settled clock level.
    logic sda_prev_q; // Previous settled data level.

    // Only stage one feeds stage two; all logic reads stage two.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    logic scl_s; // Settled clock level.
    logic sda_s; // Settled data level.
    logic scl_rise; // Clock rising edge, sample point.
    logic scl_fall; // Clock falling edge, change point.
    logic start_det; // Start or repeated start seen.
    logic stop_det; // Stop seen.
    assign scl_s = scl_sync_q[1];
    assign sda_s = sda_sync_q[1];
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    // Data edges count only while the clock stays high.
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ------------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------------
    sit_state_type state_q; // Current protocol phase.
    logic [2:0] bit_q; // Bit index within the byte.
    logic [7:0] shift_q; // Receive or transmit shift register.
    logic [7:0] ptr_q; // Register pointer byte.
    logic read_q; // Address phase selected a read.
    logic drive_low_q; // Pull the data line low.
    logic full_q; // All eight bits of the current byte are in.

    // The final sampled byte including the bit arriving now.
    function automatic logic [7:0] sit_byte(input logic [7:0] sh,
                                            input logic b);
        sit_byte = {sh[6:0], b};
    endfunction

    // Set once the eighth bit is sampled; the next clock fall clears it,
    // so stale shift contents can never pass for a fresh byte.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || start_det || stop_det || scl_fall)
        begin
            full_q <= 1'b0;
        end
        else if (scl_rise && bit_q == `SIT_LAST_BIT)
        begin
            full_q <= 1'b1;
        end
    end

    // Bits are sampled on rising clock; the line is only changed on the
    // falling clock, or released at a start or stop, so it holds otherwise while the clock is high.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= SIT_IDLE;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
            ptr_q <= `SIT_PTR_RESET;
            read_q <= 1'b0;
            drive_low_q <= 1'b0;
        end
        else if (stop_det)
        begin
            // Stop ends any transaction and releases the line.
            state_q <= SIT_IDLE;
            drive_low_q <= 1'b0;
        end
        else if (start_det)
        begin
            // Address bits follow a start at once.
            state_q <= SIT_ADDR;
            bit_q <= 3'h0;
            drive_low_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                SIT_ADDR, SIT_PTR:
                begin
                    if (scl_rise)
                    begin
                        shift_q <= sit_byte(shift_q, sda_s);
                        bit_q <= bit_q + 3'h1;
                    end
                    if (scl_fall && full_q && state_q == SIT_ADDR)
                    begin
                        // Eighth bit done: 7 address bits + direction.
                        if (shift_q[7:1] == `SIT_TARGET_ADDR)
                        begin
                            read_q <= (shift_q[0] == `SIT_DIR_READ);
                            drive_low_q <= 1'b1;
                            state_q <= SIT_ADDR_ACK;
                        end
                        else
                        begin
                            // Stay released until the next start.
                            state_q <= SIT_IDLE;
                        end
                    end
                    if (scl_fall && full_q && state_q == SIT_PTR)
                    begin
                        ptr_q <= shift_q;
                        drive_low_q <= 1'b1;
                        state_q <= SIT_PTR_ACK;
                    end
                end
                SIT_ADDR_ACK:
                begin
                    // End the acknowledge after the ninth pulse.
                    if (scl_fall)
                    begin
                        bit_q <= 3'h0;
                        if (read_q)
                        begin
                            // First data bit goes out now.
                            shift_q <= {reg_data_i[6:0], 1'b1};
                            drive_low_q <= ~reg_data_i[7];
                            state_q <= SIT_SEND;
                        end
                        else
                        begin
                            shift_q <= 8'h01;
                            drive_low_q <= 1'b0;
                            state_q <= SIT_PTR;
                        end
                    end
                end
                SIT_PTR_ACK:
                begin
                    if (scl_fall)
                    begin
                        drive_low_q <= 1'b0;
                        state_q <= SIT_IDLE;
                    end
                end
                SIT_SEND:
                begin
                    if (scl_fall)
                    begin
                        if (bit_q == `SIT_LAST_BIT)
                        begin
                            // Let the host drive its acknowledge bit.
                            drive_low_q <= 1'b0;
                            state_q <= SIT_SEND_ACK;
                        end
                        else
                        begin
                            drive_low_q <= ~shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b1};
                            bit_q <= bit_q + 3'h1;
                        end
                    end
                end
                SIT_SEND_ACK:
                begin
                    // Only one byte is offered; return to idle on the acknowledge clock rise.
                    if (scl_rise)
                    begin
                        state_q <= SIT_IDLE;
                    end
                end
                default:
                begin
                    state_q <= SIT_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Open drain: the line is only ever pulled low.
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_low_q;
    assign reg_addr_o = ptr_q;
    assign busy_o = (state_q != SIT_IDLE);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_drive_window;
        @(posedge clk_i) disable iff (rst_i)
        sda_oe_o |-> (state_q == SIT_ADDR_ACK || state_q == SIT_PTR_ACK
                      || state_q == SIT_SEND);
    endproperty
    a_drive_window: assert property (p_drive_window)
        else $error("Data line driven outside an answer slot.");
    property p_ack_match;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == SIT_ADDR_ACK && $past(state_q) == SIT_ADDR)
        |-> ($past(shift_q[7:1]) == `SIT_TARGET_ADDR) && drive_low_q;
    endproperty
    a_ack_match: assert property (p_ack_match)
        else $error("Acknowledge given to a foreign address.");
    property p_foreign_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == SIT_IDLE && $past(state_q) == SIT_ADDR)
        |-> !sda_oe_o;
    endproperty
    a_foreign_quiet: assert property (p_foreign_quiet)
        else $error("Data line driven after a foreign address.");
    property p_stable_high;
        @(posedge clk_i) disable iff (rst_i)
        (scl_s && scl_prev_q && !start_det && !stop_det)
        |=> $stable(sda_oe_o) || !scl_s || $past(stop_det || start_det);
    endproperty
    a_stable_high: assert property (p_stable_high)
        else $error("Driven data changed while the clock was high.");
    property p_stop_idle;
        @(posedge clk_i) disable iff (rst_i)
        stop_det |=> state_q == SIT_IDLE && !sda_oe_o;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("Stop did not end the transaction.");
    property p_start_addr;
        @(posedge clk_i) disable iff (rst_i)
        (start_det && !stop_det) |=> state_q == SIT_ADDR && bit_q == 3'h0;
    endproperty
    a_start_addr: assert property (p_start_addr)
        else $error("Start did not open the address phase.");
    property p_dir_bit;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == SIT_SEND) |-> read_q;
    endproperty
    a_dir_bit: assert property (p_dir_bit)
        else $error("Data sent without a read direction.");
    property p_ptr_ack;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == SIT_PTR_ACK) |-> sda_oe_o;
    endproperty
    a_ptr_ack: assert property (p_ptr_ack)
        else $error("Pointer byte not acknowledged.");
    property p_low_only;
        @(posedge clk_i) disable iff (rst_i)
        sda_oe_o |-> !sda_o;
    endproperty
    a_low_only: assert property (p_low_only)
        else $error("Data line driven high.");

endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench of the two-wire register read target.
// Assumes: Host model and bench resolve the open-drain wires together.
// Notes: Random addresses, pointers and data from a fixed seed.
`timescale 1ns/10ps
`default_nettype none
`include "sit_defs.svh"
module tb_top;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk_i, rst_i, sda_o, sda_oe_o, busy_o, scl_low, sda_low, oe_prev;
    logic [7:0] reg_data_i, data_next, reg_addr_o, exp_ptr;
    logic [5:0] scl_hist;
    logic [6:0] adr;
    logic nak;
    int err_count, cmp_count, cycles;
    wire scl_line;
    wire sda_line;
    // Pull-ups win unless some party pulls a line low.
    assign scl_line = ~scl_low;
    assign sda_line = ~(sda_low | sda_oe_o);

    sit_target i_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_line),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .reg_addr_o(reg_addr_o), .reg_data_i(reg_data_i), .busy_o(busy_o));
    sit_host i_host (.sda_i(sda_line), .scl_low_o(scl_low),
        .sda_low_o(sda_low));

    // ------------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------------
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: bit %b, want %b", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask
    // Byte the host should read: the register, or the pulled-up idle level.
    function automatic logic [7:0] exp_read(input logic hit,
        input logic [7:0] v);
        exp_read = hit ? v : 8'hFF;
    endfunction
    task automatic summarize();
        if (err_count == 0 && cmp_count > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Clock of 100 MHz.
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Register contents reach the design on clock edges only.
    always @(posedge clk_i)
    begin
        reg_data_i <= data_next;
    end

    // Wire watch: the answer moves only after the clock has been low.
    // A hang is cut short by the cycle ceiling.
    always @(posedge clk_i)
    begin
        scl_hist <= {scl_hist[4:0], scl_line};
        oe_prev <= sda_oe_o;
        if (&scl_hist && !rst_i) chk1(sda_oe_o, oe_prev);
        if (sda_oe_o === 1'b1) chk1(sda_o, 1'b0);
        cycles++;
        if (cycles == 30000)
        begin
            err_count++;
            summarize();
        end
    end

    // One full register read; a foreign address must be ignored.
    task automatic xfer(input logic [6:0] a, input logic [7:0] p,
        input logic [7:0] v);
        logic hit;
        logic [7:0] got;
        hit = (a == `SIT_TARGET_ADDR);
        data_next = v;
        i_host.start();
        i_host.send({a, 1'b0}, nak);
        chk1(nak, ~hit);
        chk1(busy_o, hit);
        i_host.send(p, nak);
        chk1(nak, ~hit);
        exp_ptr = hit ? p : exp_ptr;
        chk8(reg_addr_o, exp_ptr);
        i_host.start();
        i_host.send({a, `SIT_DIR_READ}, nak);
        chk1(nak, ~hit);
        i_host.recv(got);
        chk8(got, exp_read(hit, v));
        i_host.stop();
        #100 chk1(busy_o, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        data_next = 8'h00;
        reg_data_i = 8'h00;
        err_count = 0;
        cmp_count = 0;
        cycles = 0;
        exp_ptr = 8'h00;
        void'($urandom(32'he339));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        // Off-edge phase keeps link edges clear of clk_i edges.
        #3;
        chk8(reg_addr_o, 8'h00);
        chk1(busy_o, 1'b0);
        chk1(sda_oe_o, 1'b0);
        xfer(7'h6D, 8'h00, 8'hA5);
        xfer(7'h6D, 8'hFF, 8'h5A);
        xfer(7'h6C, 8'h12, 8'h34);
        xfer(7'h2D, 8'h56, 8'h78);
        for (int n = 0; n < 8; n++)
        begin
            adr = ($urandom % 2) ? 7'h6D : 7'($urandom);
            xfer(adr, 8'($urandom), 8'($urandom));
        end
        // Write phase ends early; a third byte is refused.
        i_host.start();
        i_host.send(8'hDA, nak);
        chk1(nak, 1'b0);
        i_host.send(8'h3C, nak);
        chk1(nak, 1'b0);
        i_host.send(8'hC3, nak);
        chk1(nak, 1'b1);
        i_host.stop();
        chk8(reg_addr_o, 8'h3C);
        summarize();
    end
endmodule
`default_nettype wire
